// ### hw/i2cs_top.sv
// Notes on behaviour
// - Slave only in mode 110 with enable.
// - Shift seven address bits MSB first, compare.
// - Address match sets flag and interrupt.
// - Eighth bit stored as master-read flag.
// - Matched address acknowledged low on ninth bit.
// - SDA fall with SCL high sets busy.
// - One interrupt for match, byte, time-out.
// - Hold SCL low until data register serviced.
// - Transmit-select picks driving or sampling SDA.
// - Data bytes eight bits, MSB first.
// - Receiver drives ack-to-send on ninth clock.
// - Transmit NACK releases SDA, waits STOP.
// - One data register for both directions.
// - Counter starts on match, clears, stops.
// - Time-out when time since last SCL fall exceeds limit.
// - Time-out stops, flags, interrupts, resets engine.
// - Time-out resets only status register.
// - Period is select plus one times 32.
// - Time-out flag stays until software clears.
// - STOP clears the busy flag.
// - Byte-done low in transfer, high after.
// - Ack-received zero when master acknowledged.
`timescale 1ns/1ps
`default_nettype none
module i2cs_top
  import i2cs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire i2cs_pin_in_t pin_in,
  output i2cs_pin_out_t pin_out,
  input wire logic sub_clock,
  output logic bus_irq
);

  typedef struct packed {
    i2cs_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [2:0] serial_mode_select;
    logic serial_enable;
    logic [7:0] own_address_reg;
    logic [7:0] shift_data_reg;
    logic byte_done_flag;
    logic addr_match_flag;
    logic bus_busy_flag;
    logic transmit_select;
    logic ack_to_send;
    logic master_read_flag;
    logic ack_received;
    logic timeout_enable;
    logic timeout_flag;
    logic [I2CS_TMO_SEL_W-1:0] timeout_select;
    logic tmo_run;
    logic sda_oe;
    logic scl_oe;
    logic irq;
    logic ack;
    logic [7:0] rdata;
  } i2cs_top_st_t;

  i2cs_top_st_t r;
  i2cs_top_st_t s;
  logic [1:0] lvl;
  logic [1:0] rise;
  logic [1:0] fall;
  logic tmo_expire;
  logic enabled;
  logic start_det;
  logic stop_det;
  logic acc;
  logic wr_go;
  logic rd_go;
  logic release_hold;
  logic [7:0] stat_rd;
  logic [7:0] tmo_rd;

  i2cs_line #(
    .N(2)
  ) u_line (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .line_in({pin_in.scl, pin_in.sda}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  i2cs_tmo u_tmo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .sub_clock(sub_clock),
    .run(r.tmo_run & r.timeout_enable),
    .clr(fall[1]),
    .sel(r.timeout_select),
    .expire(tmo_expire)
  );

  assign enabled = r.serial_enable &&
    r.serial_mode_select == I2CS_MODE_SLAVE;
  // Only START and STOP are watched; a slave never makes either edge.
  assign start_det = lvl[1] & fall[0];
  assign stop_det = lvl[1] & rise[0];
  // One wait state per access keeps read data registered.
  assign acc = (avs_read | avs_write) & ~r.ack;
  assign avs_waitrequest = acc;
  assign wr_go = avs_write & r.ack & avs_byteenable[0];
  assign rd_go = avs_read & r.ack;

  always_comb
  begin
    stat_rd = '0;
    stat_rd[I2CS_ST_DONE_POS] = r.byte_done_flag;
    stat_rd[I2CS_ST_MATCH_POS] = r.addr_match_flag;
    stat_rd[I2CS_ST_BUSY_POS] = r.bus_busy_flag;
    stat_rd[I2CS_ST_TX_POS] = r.transmit_select;
    stat_rd[I2CS_ST_ACK_TO_SEND_POS] = r.ack_to_send;
    stat_rd[I2CS_ST_RW_POS] = r.master_read_flag;
    stat_rd[I2CS_ST_ACK_RECEIVED_POS] = r.ack_received;
    tmo_rd = {r.timeout_enable, r.timeout_flag, r.timeout_select};
  end

  always_comb
  begin
    s = r;
    s.irq = 1'b0;
    s.ack = acc;
    release_hold = 1'b0;
    if (acc && avs_read)
    begin
      unique case (avs_address)
        I2CS_OFS_MODE: s.rdata = {r.serial_mode_select, 3'h0,
          r.serial_enable, 1'b0};
        I2CS_OFS_STAT: s.rdata = stat_rd;
        I2CS_OFS_ADDR: s.rdata = r.own_address_reg;
        I2CS_OFS_DATA: s.rdata = r.shift_data_reg;
        I2CS_OFS_TMO: s.rdata = tmo_rd;
        default: s.rdata = 8'h00;
      endcase
    end
    if (wr_go)
    begin
      unique case (avs_address)
        I2CS_OFS_MODE:
        begin
          s.serial_mode_select = avs_writedata[I2CS_MODE_SEL_POS +: 3];
          s.serial_enable = avs_writedata[I2CS_MODE_EN_POS];
        end
        I2CS_OFS_STAT:
        begin
          s.transmit_select = avs_writedata[I2CS_ST_TX_POS];
          s.ack_to_send = avs_writedata[I2CS_ST_ACK_TO_SEND_POS];
          s.master_read_flag = avs_writedata[I2CS_ST_RW_POS];
        end
        I2CS_OFS_ADDR: s.own_address_reg = avs_writedata[7:0];
        I2CS_OFS_DATA:
        begin
          s.shift_data_reg = avs_writedata[7:0];
          release_hold = r.transmit_select;
        end
        I2CS_OFS_TMO:
        begin
          s.timeout_enable = avs_writedata[I2CS_TMO_EN_POS];
          s.timeout_flag = avs_writedata[I2CS_TMO_FLAG_POS];
          s.timeout_select = avs_writedata[I2CS_TMO_SEL_W-1:0];
        end
        default: ;
      endcase
    end
    if (rd_go && avs_address == I2CS_OFS_DATA && !r.transmit_select)
      release_hold = 1'b1;

    if (!enabled)
    begin
      s.st = I2CS_IDLE;
      s.sda_oe = 1'b0;
      s.scl_oe = 1'b0;
      s.bus_busy_flag = 1'b0;
      s.tmo_run = 1'b0;
    end
    else if (stop_det)
    begin
      s.st = I2CS_IDLE;
      s.sda_oe = 1'b0;
      s.scl_oe = 1'b0;
      s.bus_busy_flag = 1'b0;
      s.tmo_run = 1'b0;
    end
    else if (start_det)
    begin
      s.st = I2CS_ADDR;
      s.cnt = '0;
      s.sda_oe = 1'b0;
      s.scl_oe = 1'b0;
      s.bus_busy_flag = 1'b1;
      s.addr_match_flag = 1'b0;
    end
    else
    begin
      unique case (r.st)
        I2CS_IDLE, I2CS_WSTOP: s.sda_oe = 1'b0;
        I2CS_ADDR:
        begin
          if (rise[1])
          begin
            s.sh = {r.sh[6:0], lvl[0]};
            s.cnt = r.cnt + 1'b1;
            if (r.cnt == I2CS_BITS_BYTE - 4'h1)
            begin
              if (r.sh[6:0] == r.own_address_reg[7:1])
              begin
                s.addr_match_flag = 1'b1;
                s.master_read_flag = lvl[0];
                s.irq = 1'b1;
                s.tmo_run = 1'b1;
                s.st = I2CS_AACK;
              end
              else
                s.st = I2CS_WSTOP;
            end
          end
        end
        I2CS_AACK:
        begin
          // First fall opens the ninth bit, the second one closes it.
          if (fall[1] && !r.sda_oe)
            s.sda_oe = 1'b1;
          else if (fall[1])
          begin
            s.sda_oe = 1'b0;
            s.scl_oe = 1'b1;
            s.st = I2CS_HOLD;
          end
        end
        I2CS_HOLD:
        begin
          s.scl_oe = 1'b1;
          if (release_hold)
          begin
            s.scl_oe = 1'b0;
            s.byte_done_flag = 1'b0;
            // Cleared here so a later byte interrupt reads as data.
            s.addr_match_flag = 1'b0;
            s.cnt = '0;
            s.st = I2CS_DATA;
            if (r.transmit_select)
            begin
              s.sh = s.shift_data_reg;
              s.sda_oe = ~s.shift_data_reg[7];
            end
          end
        end
        I2CS_DATA:
        begin
          if (rise[1])
          begin
            if (!r.transmit_select)
              s.sh = {r.sh[6:0], lvl[0]};
            s.cnt = r.cnt + 1'b1;
          end
          if (fall[1])
          begin
            if (r.cnt == I2CS_BITS_BYTE)
            begin
              s.st = I2CS_DACK;
              if (r.transmit_select)
                s.sda_oe = 1'b0;
              else
              begin
                s.shift_data_reg = r.sh;
                s.sda_oe = ~r.ack_to_send;
              end
            end
            else if (r.transmit_select)
            begin
              s.sh = {r.sh[6:0], 1'b0};
              s.sda_oe = ~r.sh[6];
            end
          end
        end
        I2CS_DACK:
        begin
          if (rise[1] && r.transmit_select)
            s.ack_received = lvl[0];
          if (fall[1])
          begin
            s.sda_oe = 1'b0;
            s.byte_done_flag = 1'b1;
            s.irq = 1'b1;
            if (r.transmit_select && r.ack_received)
              s.st = I2CS_WSTOP;
            else
            begin
              s.scl_oe = 1'b1;
              s.st = I2CS_HOLD;
            end
          end
        end
        default: s.st = I2CS_IDLE;
      endcase
    end

    // A time-out beats every other event, and the flag set beats a clear.
    if (tmo_expire)
    begin
      s.timeout_enable = 1'b0;
      s.timeout_flag = 1'b1;
      s.irq = 1'b1;
      s.tmo_run = 1'b0;
      s.st = I2CS_IDLE;
      s.sda_oe = 1'b0;
      s.scl_oe = 1'b0;
      s.byte_done_flag = I2CS_DONE_RST;
      s.addr_match_flag = 1'b0;
      s.bus_busy_flag = 1'b0;
      s.transmit_select = 1'b0;
      s.ack_to_send = 1'b0;
      s.master_read_flag = 1'b0;
      s.ack_received = I2CS_ACK_RECEIVED_RST;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      r <= '0;
      r.st <= I2CS_IDLE;
      r.serial_mode_select <= I2CS_MODE_RST;
      r.byte_done_flag <= I2CS_DONE_RST;
      r.ack_received <= I2CS_ACK_RECEIVED_RST;
      {r.timeout_enable, r.timeout_flag, r.timeout_select} <= I2CS_TMO_RST;
    end
    else
      r <= s;
  end

  // Open-drain pins: the output level is always low.
  assign pin_out.sda_o = 1'b0;
  assign pin_out.scl_o = 1'b0;
  assign pin_out.sda_oe = r.sda_oe;
  assign pin_out.scl_oe = r.scl_oe;
  assign avs_readdata = {24'h000000, r.rdata};
  assign bus_irq = r.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  a_start_busy: assert property (enabled && start_det && !tmo_expire
    |=> r.bus_busy_flag) else $error("START did not set busy");
  a_stop_free: assert property (enabled && stop_det && !start_det
    |=> !r.bus_busy_flag && r.st == I2CS_IDLE)
    else $error("STOP did not clear busy");
  a_match_irq: assert property ($rose(r.addr_match_flag)
    |-> r.irq && r.st == I2CS_AACK) else $error("match without irq");
  a_addr_ack: assert property (r.st == I2CS_AACK && $rose(r.sda_oe)
    |-> $past(fall[1])) else $error("address ack not on fall");
  a_hold_scl: assert property (r.st == I2CS_HOLD |-> r.scl_oe)
    else $error("SCL released while holding");
  a_done_clear: assert property (r.st == I2CS_HOLD ##1 r.st == I2CS_DATA
    |-> !r.byte_done_flag && !r.scl_oe)
    else $error("byte done not cleared on transfer");
  a_tx_bit: assert property (r.st == I2CS_DATA && r.transmit_select
    |-> r.sda_oe == ~r.sh[7]) else $error("wrong transmit bit");
  a_tmo_effect: assert property (tmo_expire |=> r.timeout_flag
    && !r.timeout_enable && r.st == I2CS_IDLE && r.byte_done_flag
    && r.irq) else $error("time-out effects missing");
  a_tmo_sticky: assert property (r.timeout_flag
    && !(wr_go && avs_address == I2CS_OFS_TMO) |=> r.timeout_flag)
    else $error("time-out flag lost");
  a_pins_low: assert property (pin_out.sda_o == 1'b0
    && pin_out.scl_o == 1'b0) else $error("line driven high");
  a_disabled_quiet: assert property (!enabled ##1 !enabled
    |-> !r.sda_oe && !r.scl_oe) else $error("pins active when off");

  c_match: cover property ($rose(r.addr_match_flag));
  c_tx_byte: cover property (r.st == I2CS_DACK && r.transmit_select
    ##[1:200] r.st == I2CS_HOLD);
  c_rx_byte: cover property (r.st == I2CS_DACK && !r.transmit_select
    && r.sda_oe);
  c_timeout: cover property (tmo_expire);

endmodule : i2cs_top
`default_nettype wire

// ### hw/i2cs_pkg.sv
package i2cs_pkg;

  // Register byte offsets on the Avalon slave.
  localparam logic [4:0] I2CS_OFS_MODE = 5'h00;
  localparam logic [4:0] I2CS_OFS_STAT = 5'h04;
  localparam logic [4:0] I2CS_OFS_ADDR = 5'h08;
  localparam logic [4:0] I2CS_OFS_DATA = 5'h0C;
  localparam logic [4:0] I2CS_OFS_TMO = 5'h10;

  // Mode control fields.
  localparam int I2CS_MODE_SEL_POS = 5;
  localparam int I2CS_MODE_EN_POS = 1;
  localparam logic [2:0] I2CS_MODE_SLAVE = 3'h6;
  localparam logic [2:0] I2CS_MODE_RST = 3'h7;

  // Status and control fields.
  localparam int I2CS_ST_DONE_POS = 7;
  localparam int I2CS_ST_MATCH_POS = 6;
  localparam int I2CS_ST_BUSY_POS = 5;
  localparam int I2CS_ST_TX_POS = 4;
  localparam int I2CS_ST_ACK_TO_SEND_POS = 3;
  localparam int I2CS_ST_RW_POS = 2;
  localparam int I2CS_ST_ACK_RECEIVED_POS = 0;
  localparam logic I2CS_DONE_RST = 1'b1;
  localparam logic I2CS_ACK_RECEIVED_RST = 1'b1;

  // Time-out control fields.
  localparam int I2CS_TMO_EN_POS = 7;
  localparam int I2CS_TMO_FLAG_POS = 6;
  localparam int I2CS_TMO_SEL_W = 6;
  localparam logic [7:0] I2CS_TMO_RST = 8'h00;

  // Time-out counter runs on the sub clock divided by this figure.
  localparam int I2CS_TMO_DIV = 32;
  localparam int I2CS_TMO_DIV_W = $clog2(I2CS_TMO_DIV);

  // Bits of an address phase and of a data byte, before the ack bit.
  localparam logic [3:0] I2CS_BITS_BYTE = 4'h8;

  typedef enum logic [2:0] {
    I2CS_IDLE = 3'h0,
    I2CS_ADDR = 3'h1,
    I2CS_AACK = 3'h3,
    I2CS_HOLD = 3'h2,
    I2CS_DATA = 3'h6,
    I2CS_DACK = 3'h7,
    I2CS_WSTOP = 3'h5
  } i2cs_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2cs_pin_in_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } i2cs_pin_out_t;

endpackage : i2cs_pkg

// ### hw/i2cs_line.sv
`timescale 1ns/1ps
`default_nettype none
module i2cs_line
  import i2cs_pkg::*;
#(
  parameter int N = 2
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [N-1:0] line_in,
  output logic [N-1:0] level,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);

  typedef struct packed {
    logic [N-1:0] cur;
    logic [N-1:0] prev;
  } i2cs_line_st_t;

  i2cs_line_st_t st_r;
  i2cs_line_st_t st_nxt;

  // Idle bus lines float high, so both history bits start at one.
  always_comb
  begin
    st_nxt.cur = line_in;
    st_nxt.prev = st_r.cur;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      st_r <= '1;
    else
      st_r <= st_nxt;
  end

  for (genvar i = 0; i < N; i++)
  begin : g_edge
    assign level[i] = st_r.cur[i];
    assign rise[i] = st_r.cur[i] & ~st_r.prev[i];
    assign fall[i] = ~st_r.cur[i] & st_r.prev[i];
  end

endmodule : i2cs_line
`default_nettype wire

// ### hw/i2cs_tmo.sv
`timescale 1ns/1ps
`default_nettype none
module i2cs_tmo
  import i2cs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sub_clock,
  input wire logic run,
  input wire logic clr,
  input wire logic [I2CS_TMO_SEL_W-1:0] sel,
  output logic expire
);

  typedef struct packed {
    logic sub_prev;
    logic [I2CS_TMO_DIV_W-1:0] div;
    logic [I2CS_TMO_SEL_W:0] cnt;
    logic expire;
  } i2cs_tmo_st_t;

  i2cs_tmo_st_t st_r;
  i2cs_tmo_st_t st_nxt;
  logic tick;
  logic [I2CS_TMO_SEL_W:0] limit;

  always_comb
  begin
    st_nxt = st_r;
    tick = sub_clock & ~st_r.sub_prev;
    limit = {1'b0, sel} + 7'h01;
    st_nxt.sub_prev = sub_clock;
    st_nxt.expire = 1'b0;
    // The divider restarts with the count so every period is whole.
    if (!run || clr)
    begin
      st_nxt.div = '0;
      st_nxt.cnt = '0;
    end
    else if (tick)
    begin
      st_nxt.div = st_r.div + 1'b1;
      if (st_r.div == I2CS_TMO_DIV_W'(I2CS_TMO_DIV - 1))
        st_nxt.cnt = st_r.cnt + 1'b1;
    end
    if (run && !clr && st_r.cnt == limit && !st_r.expire)
      st_nxt.expire = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign expire = st_r.expire;

endmodule : i2cs_tmo
`default_nettype wire

// ### test/i2cs_mstr.sv
`timescale 1ns/1ps
`default_nettype none
module i2cs_mstr
  import i2cs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_oe,
  output logic sda_oe,
  output logic stuck
);
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    stuck = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // The slave may stretch SCL, so wait for the wire, but never forever.
  task automatic rise_scl();
    int n;
    n = 0;
    scl_oe <= 1'b0;
    cyc(1);
    while (scl_w !== 1'b1 && n < 4000)
    begin
      cyc(1);
      n++;
    end
    stuck <= (scl_w !== 1'b1);
  endtask : rise_scl

  task automatic start();
    sda_oe <= 1'b0;
    cyc(6);
    rise_scl();
    cyc(8);
    sda_oe <= 1'b1;
    cyc(8);
    scl_oe <= 1'b1;
    cyc(2);
  endtask : start

  task automatic stop();
    sda_oe <= 1'b1;
    cyc(6);
    rise_scl();
    cyc(8);
    sda_oe <= 1'b0;
    cyc(8);
  endtask : stop

  // SDA moves two cycles after SCL falls, keeping hold time on the wire.
  task automatic bit_io(input logic b, output logic r);
    sda_oe <= ~b;
    cyc(6);
    rise_scl();
    cyc(3);
    r = sda_w;
    cyc(4);
    scl_oe <= 1'b1;
    cyc(2);
  endtask : bit_io

  task automatic xfer(input logic [7:0] d, input logic ak,
    output logic [7:0] q, output logic ka);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ak, ka);
  endtask : xfer
endmodule : i2cs_mstr
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import i2cs_pkg::*;
;
  localparam int TMO_CYC = 2 * I2CS_TMO_DIV * 4;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic sub_clock = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic bus_irq;
  i2cs_pin_in_t pin_in;
  i2cs_pin_out_t pin_out;
  logic m_scl_oe;
  logic m_sda_oe;
  logic m_stuck;
  int error_cnt = 0;
  int n_tests = 0;
  int irq_cnt = 0;
  logic [7:0] q;
  logic ka;
  logic [7:0] rv;

  always #50 clk_sys = ~clk_sys;
  always
  begin
    repeat (2) @(posedge clk_sys);
    sub_clock <= ~sub_clock;
  end
  // Open-drain wires with pull-ups.
  assign pin_in = {~(m_scl_oe | pin_out.scl_oe), ~(m_sda_oe | pin_out.sda_oe)};

  i2cs_top uut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .sub_clock(sub_clock),
    .bus_irq(bus_irq));
  i2cs_mstr m (.clk_sys(clk_sys), .scl_w(pin_in.scl), .sda_w(pin_in.sda),
    .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .stuck(m_stuck));

  always @(posedge clk_sys)
    if (bus_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  always @(posedge clk_sys)
    if (m_stuck === 1'b1)
    begin
      error_cnt++;
      tally_and_finish();
    end

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    rv = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50)
    begin
      error_cnt++;
      tally_and_finish();
    end
    @(posedge clk_sys);
  endtask : bus

  task automatic rc(input string nm, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, e, rv);
  endtask : rc

  task automatic t_reset();
    rc("mode", I2CS_OFS_MODE, 8'hE0);
    rc("stat", I2CS_OFS_STAT, 8'h81);
    rc("addr", I2CS_OFS_ADDR, 8'h00);
    rc("data", I2CS_OFS_DATA, 8'h00);
    rc("tmo", I2CS_OFS_TMO, 8'h00);
    rc("unmapped", 5'h14, 8'h00);
    // A write without lane 0 enabled must leave the register alone.
    avs_byteenable <= 4'h0;
    bus(1'b1, I2CS_OFS_ADDR, 8'h77);
    avs_byteenable <= 4'h1;
    rc("be_off", I2CS_OFS_ADDR, 8'h00);
  endtask : t_reset

  task automatic t_off();
    bus(1'b1, I2CS_OFS_ADDR, 8'h5A);
    m.start();
    m.xfer(8'h5A, 1'b1, q, ka);
    chk("ack_off", 8'h01, 8'(ka));
    m.stop();
    bus(1'b1, I2CS_OFS_MODE, 8'hC2);
  endtask : t_off

  // Own address shifted up one bit must not be taken as a match.
  task automatic t_miss();
    m.start();
    bus(1'b0, I2CS_OFS_STAT, 8'h00);
    chk("busy", 8'h01, 8'(rv[I2CS_ST_BUSY_POS]));
    m.xfer(8'hB4, 1'b1, q, ka);
    chk("ack_miss", 8'h01, 8'(ka));
    m.stop();
    bus(1'b0, I2CS_OFS_STAT, 8'h00);
    chk("free", 8'h00, 8'(rv[I2CS_ST_BUSY_POS]));
  endtask : t_miss

  task automatic t_rx();
    int i0;
    i0 = irq_cnt;
    m.start();
    m.xfer(8'h5A, 1'b1, q, ka);
    chk("ack_adr", 8'h00, 8'(ka));
    chk("irq_adr", 8'(i0 + 1), 8'(irq_cnt));
    bus(1'b0, I2CS_OFS_STAT, 8'h00);
    chk("match", 8'h01, 8'(rv[I2CS_ST_MATCH_POS]));
    chk("rw_wr", 8'h00, 8'(rv[I2CS_ST_RW_POS]));
    bus(1'b0, I2CS_OFS_DATA, 8'h00);
    m.xfer(8'hA6, 1'b1, q, ka);
    chk("ack_rx", 8'h00, 8'(ka));
    bus(1'b0, I2CS_OFS_STAT, 8'h00);
    chk("done_rx", 8'h01, 8'(rv[I2CS_ST_DONE_POS]));
    chk("irq_rx", 8'(i0 + 2), 8'(irq_cnt));
    rc("data_rx", I2CS_OFS_DATA, 8'hA6);
    bus(1'b1, I2CS_OFS_STAT, 8'h08);
    m.xfer(8'h3A, 1'b1, q, ka);
    chk("nack_rx", 8'h01, 8'(ka));
    rc("data_rx2", I2CS_OFS_DATA, 8'h3A);
    m.stop();
  endtask : t_rx

  task automatic t_tx();
    m.start();
    m.xfer(8'h5B, 1'b1, q, ka);
    chk("ack_adr2", 8'h00, 8'(ka));
    bus(1'b0, I2CS_OFS_STAT, 8'h00);
    chk("rw_rd", 8'h01, 8'(rv[I2CS_ST_RW_POS]));
    bus(1'b1, I2CS_OFS_STAT, 8'h14);
    repeat (40) @(posedge clk_sys);
    chk("stretch", 8'h01, 8'(pin_out.scl_oe));
    bus(1'b1, I2CS_OFS_DATA, 8'hC6);
    m.xfer(8'hFF, 1'b0, q, ka);
    chk("tx1", 8'hC6, q);
    bus(1'b0, I2CS_OFS_STAT, 8'h00);
    chk("rxak0", 8'h00, 8'(rv[I2CS_ST_ACK_RECEIVED_POS]));
    bus(1'b1, I2CS_OFS_DATA, 8'h96);
    m.xfer(8'hFF, 1'b1, q, ka);
    chk("tx2", 8'h96, q);
    bus(1'b0, I2CS_OFS_STAT, 8'h00);
    chk("rxak1", 8'h01, 8'(rv[I2CS_ST_ACK_RECEIVED_POS]));
    repeat (20) @(posedge clk_sys);
    chk("let_go", 8'h00, {6'h0, pin_out.scl_oe, pin_out.sda_oe});
    m.stop();
  endtask : t_tx

  task automatic t_tmo();
    int n;
    n = 0;
    bus(1'b1, I2CS_OFS_DATA, 8'h5C);
    bus(1'b1, I2CS_OFS_TMO, 8'h81);
    m.start();
    m.xfer(8'h5A, 1'b1, q, ka);
    while (bus_irq !== 1'b1 && n < 1000)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk("tmo_time", 8'h01, 8'(n > TMO_CYC - 12 && n < TMO_CYC + 16));
    rc("tmo_reg", I2CS_OFS_TMO, 8'h41);
    rc("stat_tmo", I2CS_OFS_STAT, 8'h81);
    rc("mode_tmo", I2CS_OFS_MODE, 8'hC2);
    rc("addr_tmo", I2CS_OFS_ADDR, 8'h5A);
    rc("data_tmo", I2CS_OFS_DATA, 8'h5C);
    chk("scl_free", 8'h00, 8'(pin_out.scl_oe));
    repeat (100) @(posedge clk_sys);
    rc("flag_held", I2CS_OFS_TMO, 8'h41);
    bus(1'b1, I2CS_OFS_TMO, 8'h00);
    rc("flag_clr", I2CS_OFS_TMO, 8'h00);
    m.stop();
  endtask : t_tmo

  initial
  begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_off();
    t_miss();
    t_rx();
    t_tx();
    t_tmo();
    chk("pin_o", 8'h00, {6'h0, pin_out.scl_o, pin_out.sda_o});
    tally_and_finish();
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
